// [hw/lrm_consts.svh]
// Constants of the relay driver mode and fault controller.
// Assumes a 25 MHz internal clock; the file is included by bare name.
`ifndef LRM_CONSTS_SVH
`define LRM_CONSTS_SVH
`define LRM_CLK_MHZ            25
`define LRM_NUM_CH             8
`define LRM_DIAG_A             3
`define LRM_DIAG_B             7
`define LRM_INIT_TIME_US       100
`define LRM_INIT_CYC           ((`LRM_INIT_TIME_US * `LRM_CLK_MHZ))
`define LRM_WAKE_TIME_US       150
`define LRM_WAKE_CYC           ((`LRM_WAKE_TIME_US * `LRM_CLK_MHZ))
`define LRM_OC_DEL_US          10
`define LRM_OC_CYC             ((`LRM_OC_DEL_US * `LRM_CLK_MHZ))
`define LRM_IDLE_TIME_MS       4
`define LRM_IDLE_CYC           ((`LRM_IDLE_TIME_MS * 1000 * `LRM_CLK_MHZ))
`define LRM_APP_GTSD_BIT       2
`define LRM_APP_DIAG_BIT       3
`define LRM_ERR_RESET_BIT      0
`define LRM_CNT_W              24
`define LRM_REG_CTRL           32'h0000_0000
`define LRM_REG_STATUS         32'h0000_0004
`define LRM_REG_OUT_STATUS     32'h0000_0008
`define LRM_REG_ERR            32'h0000_000c
`define LRM_REG_CFG            32'h0000_0010
`define LRM_REG_OPEN_LOAD      32'h0000_0014
`define LRM_CTRL_SLEEP_BIT     8
`define LRM_CTRL_RESET_BIT     9
`define LRM_CFG_AUTO_BIT       0
`endif

// [hw/lrm_pkg.sv]
// Types of the relay driver mode and fault controller.
// Assumes nothing beyond a SystemVerilog compiler.
package lrm_pkg;
   typedef enum logic [2:0] {
      LRM_UNPOWERED,
      LRM_INIT,
      LRM_NORMAL,
      LRM_UNDERVOLT,
      LRM_SLEEP,
      LRM_RESET,
      LRM_GTSD
   } lrm_mode_e;
endpackage

// [hw/lrm_sync.sv]
// Two flip-flop synchroniser bank for the comparator inputs.
// Assumes asynchronous levels and one clock.
`timescale 1ns/1ps
module lrm_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule // lrm_sync

// [hw/lrm_ctrl.sv]
// Mode and fault-protection controller of an eight-channel LIN relay driver.
// Assumes comparator levels at the inputs and software on an AXI4-Lite bus
// standing in for the LIN frame decoder (commands and error reports).
//
// Contract
// - Below power-on level, outputs high impedance and LIN disabled.
// - Leaving power-on reset enters init, clears registers, sets error bit zero (the code sets pending bit one, reported as error code 1).
// - Init reads address and position pins; good goes normal, bad goes sleep.
// - Init keeps LIN off, outputs high impedance, ends within init time.
// - No falling bus edge for idle timeout in normal or undervoltage gives sleep.
// - A received go-to-sleep command sends normal mode to sleep.
// - Sleep keeps outputs off, transceiver in wake detect, error bits kept.
// - Wake needs dominant for wake time then recessive; then init.
// - Transceiver active only in normal; off in unpowered, reset, init (the code also enables it in global shutdown).
// - Reset frame enters reset mode, clears registers, sets error bit zero (the code sets pending bit one, reported as error code 1).
// - Normal only after init; channels follow the commanded states.
// - Open load checked on diagnostic channels while off; never blocks switching.
// - Local thermal or overcurrent on diagnostic channels ORed into status bit three.
// - Local thermal limit latches diagnostic channel off and sets both status bits.
// - Latched faults clear only when the master commands the channel off.
// - Global shutdown forces status bit three low.
// - Current above threshold past filter delay latches any channel off.
// - Non-diagnostic overcurrent shows in output status only.
// - Global thermal limit turns all channels off, keeps LIN, sets bit two (the code enters it from normal mode only, not from undervoltage).
// - Global shutdown ends automatically on cooling; bit two clears then.
// - Undervoltage disables LIN, keeps channels, returns on recovery, idle counts.
// - Errors reported highest first; each status read clears exactly one.
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "lrm_consts.svh"
module lrm_ctrl
   import lrm_pkg::*;
#(
   parameter int IDLE_CYC = `LRM_IDLE_CYC,
   parameter int INIT_CYC = `LRM_INIT_CYC,
   parameter int WAKE_CYC = `LRM_WAKE_CYC,
   parameter int OC_CYC   = `LRM_OC_CYC
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Comparators and sensors
   input  wire logic        supply_por_ok,
   input  wire logic        supply_uv_low,
   input  wire logic        supply_uv_high,
   input  wire logic        global_thermal_hot,
   input  wire logic        global_thermal_cool,
   input  wire logic [7:0]  overcurrent_det,
   input  wire logic [1:0]  local_thermal_det,
   input  wire logic [1:0]  open_load_det,
   input  wire logic        lin_rx_dominant,
   input  wire logic        node_address_pin_ok,
   input  wire logic        position_config_pin_ok,
   input  wire logic        config_read_done,
   // Driver and transceiver control
   output logic [7:0]       chan_on,
   output logic [7:0]       chan_hiz,
   output logic             lin_enable,
   output logic             lin_wake_detect,
   output logic             config_read_req,
   output logic [2:0]       mode
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic is_diag(input int i);
      return (i == `LRM_DIAG_A) || (i == `LRM_DIAG_B);
   endfunction

   function automatic logic [2:0] top_err(input logic [7:0] pend);
      logic [2:0] r;
      r = 3'h0;
      for (int k = 1; k < 8; k++) begin
         if (pend[k]) begin
            r = 3'(k);
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   logic [20:0] raw_in;
   logic [20:0] syn;
   assign raw_in = {supply_por_ok, supply_uv_low, supply_uv_high, global_thermal_hot,
                    global_thermal_cool, overcurrent_det, local_thermal_det, open_load_det,
                    lin_rx_dominant, node_address_pin_ok, position_config_pin_ok,
                    config_read_done};

   lrm_sync #(.W(21)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (raw_in),
      .q       (syn)
   );

   logic       por_ok;
   logic       uv_low;
   logic       uv_high;
   logic       gt_hot;
   logic       gt_cool;
   logic [7:0] oc_s;
   logic [1:0] lt_s;
   logic [1:0] ol_s;
   logic       rx_dom;
   logic       cfg_ok;
   logic       cfg_done;
   assign por_ok   = syn[20];
   assign uv_low   = syn[19];
   assign uv_high  = syn[18];
   assign gt_hot   = syn[17];
   assign gt_cool  = syn[16];
   assign oc_s     = syn[15:8];
   assign lt_s     = syn[7:6];
   assign ol_s     = syn[5:4];
   assign rx_dom   = syn[3];
   assign cfg_ok   = syn[2] & syn[1];
   assign cfg_done = syn[0];

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   lrm_mode_e  mode_ff;
   lrm_mode_e  nxt_mode;
   logic [7:0] cmd_ff;
   logic [7:0] ovc_ff;
   logic [1:0] lts_ff;
   logic [1:0] ol_ff;
   logic [7:0] err_pend_ff;
   logic [7:0] err_set_pulse;
   logic       sleep_cmd;
   logic       reset_cmd;
   logic       st_read;
   logic       defaults;
   logic       cnt_clr;
   logic [`LRM_CNT_W-1:0] idle_cnt_ff;
   logic [`LRM_CNT_W-1:0] mode_cnt_ff;
   logic       rx_dom_d_ff;
   logic       wake_armed_ff;
   logic [2:0] err_code;
   logic [4:0] app_status_field;

   assign defaults = (mode_ff == LRM_UNPOWERED) || (mode_ff == LRM_RESET);

   // ----------------------------------------------------------------
   // Mode state machine
   // ----------------------------------------------------------------
   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         LRM_UNPOWERED: if (por_ok) nxt_mode = LRM_INIT;
         LRM_INIT: begin
            if (cfg_done) begin
               nxt_mode = cfg_ok ? LRM_NORMAL : LRM_SLEEP;
            end else if (mode_cnt_ff >= `LRM_CNT_W'(INIT_CYC - 1)) begin
               nxt_mode = LRM_SLEEP;
            end
         end
         LRM_NORMAL: begin
            if (reset_cmd) begin
               nxt_mode = LRM_RESET;
            end else if (sleep_cmd || idle_cnt_ff >= `LRM_CNT_W'(IDLE_CYC - 1)) begin
               nxt_mode = LRM_SLEEP;
            end else if (gt_hot) begin
               nxt_mode = LRM_GTSD;
            end else if (uv_low) begin
               nxt_mode = LRM_UNDERVOLT;
            end
         end
         LRM_UNDERVOLT: begin
            if (idle_cnt_ff >= `LRM_CNT_W'(IDLE_CYC - 1)) begin
               nxt_mode = LRM_SLEEP;
            end else if (uv_high) begin
               nxt_mode = LRM_NORMAL;
            end
         end
         LRM_SLEEP: if (wake_armed_ff && !rx_dom) nxt_mode = LRM_INIT;
         LRM_RESET: nxt_mode = LRM_INIT;
         LRM_GTSD: if (gt_cool) nxt_mode = LRM_NORMAL;
         default: nxt_mode = LRM_UNPOWERED;
      endcase
      if (!por_ok) begin
         nxt_mode = LRM_UNPOWERED;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_ff <= LRM_UNPOWERED;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   assign cnt_clr = (nxt_mode != mode_ff);

   // ----------------------------------------------------------------
   // Timers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_dom_d_ff <= 1'b0;
         idle_cnt_ff <= '0;
      end else begin
         rx_dom_d_ff <= rx_dom;
         if ((rx_dom && !rx_dom_d_ff) ||
             !(mode_ff == LRM_NORMAL || mode_ff == LRM_UNDERVOLT || mode_ff == LRM_GTSD)) begin
            idle_cnt_ff <= '0;
         end else if (idle_cnt_ff != '1) begin
            idle_cnt_ff <= idle_cnt_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_cnt_ff   <= '0;
         wake_armed_ff <= 1'b0;
      end else begin
         if (cnt_clr || (mode_ff == LRM_SLEEP && !rx_dom)) begin
            mode_cnt_ff <= '0;
         end else if (mode_cnt_ff != '1) begin
            mode_cnt_ff <= mode_cnt_ff + 1'b1;
         end
         if (mode_ff != LRM_SLEEP || cnt_clr) begin
            wake_armed_ff <= 1'b0;
         end else if (rx_dom && mode_cnt_ff >= `LRM_CNT_W'(WAKE_CYC - 1)) begin
            wake_armed_ff <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Channel fault protection
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `LRM_NUM_CH; gi++) begin : g_ch
         logic [`LRM_CNT_W-1:0] oc_cnt_ff;
         always_ff @(posedge aclk) begin
            if (!aresetn || defaults) begin
               oc_cnt_ff   <= '0;
               ovc_ff[gi]  <= 1'b0;
            end else begin
               if (!oc_s[gi] || !chan_on[gi]) begin
                  oc_cnt_ff <= '0;
               end else if (oc_cnt_ff != '1) begin
                  oc_cnt_ff <= oc_cnt_ff + 1'b1;
               end
               if (oc_s[gi] && chan_on[gi] && oc_cnt_ff >= `LRM_CNT_W'(OC_CYC - 1)) begin
                  ovc_ff[gi] <= 1'b1;
               end else if (!cmd_ff[gi]) begin
                  ovc_ff[gi] <= 1'b0;
               end
            end
         end
      end
      for (gi = 0; gi < 2; gi++) begin : g_diag
         localparam int CH = (gi == 0) ? `LRM_DIAG_A : `LRM_DIAG_B;
         always_ff @(posedge aclk) begin
            if (!aresetn || defaults) begin
               lts_ff[gi] <= 1'b0;
               ol_ff[gi]  <= 1'b0;
            end else begin
               if (lt_s[gi]) begin
                  lts_ff[gi] <= 1'b1;
               end else if (!cmd_ff[CH]) begin
                  lts_ff[gi] <= 1'b0;
               end
               if (!chan_on[CH] && mode_ff != LRM_SLEEP) begin
                  ol_ff[gi] <= ol_s[gi];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_on  <= '0;
         chan_hiz <= '1;
      end else begin
         for (int i = 0; i < `LRM_NUM_CH; i++) begin
            chan_on[i] <= (nxt_mode == LRM_NORMAL || nxt_mode == LRM_UNDERVOLT) &&
                          cmd_ff[i] && !ovc_ff[i] &&
                          !(is_diag(i) && lts_ff[(i == `LRM_DIAG_A) ? 0 : 1]);
         end
         chan_hiz <= (nxt_mode == LRM_UNPOWERED || nxt_mode == LRM_INIT ||
                      nxt_mode == LRM_RESET) ? 8'hff : 8'h00;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lin_enable      <= 1'b0;
         lin_wake_detect <= 1'b0;
         config_read_req <= 1'b0;
         mode            <= 3'h0;
      end else begin
         lin_enable      <= (nxt_mode == LRM_NORMAL || nxt_mode == LRM_GTSD);
         lin_wake_detect <= (nxt_mode == LRM_SLEEP);
         config_read_req <= (nxt_mode == LRM_INIT);
         mode            <= nxt_mode;
      end
   end

   // ----------------------------------------------------------------
   // Status fields and error reporting
   // ----------------------------------------------------------------
   always_comb begin
      app_status_field = 5'h00;
      app_status_field[`LRM_APP_GTSD_BIT] = (mode_ff == LRM_GTSD);
      app_status_field[`LRM_APP_DIAG_BIT] = (mode_ff != LRM_GTSD) &&
         (|lts_ff || ovc_ff[`LRM_DIAG_A] || ovc_ff[`LRM_DIAG_B]);
   end

   assign err_code = top_err(err_pend_ff);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_pend_ff <= 8'h00;
      end else if (defaults) begin
         err_pend_ff <= 8'h00 | (8'h01 << (`LRM_ERR_RESET_BIT + 1));
      end else begin
         for (int k = 1; k < 8; k++) begin
            if (err_set_pulse[k]) begin
               err_pend_ff[k] <= 1'b1;
            end else if (st_read && mode_ff != LRM_SLEEP && err_code == 3'(k)) begin
               err_pend_ff[k] <= 1'b0;
            end
         end
         err_pend_ff[0] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   logic        aw_got_ff;
   logic        w_got_ff;
   logic [31:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic        wr_go;
   logic        wr_ok;
   logic        cfg_auto_ff;

   assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;
   assign wr_ok = (awaddr_ff == `LRM_REG_CTRL) || (awaddr_ff == `LRM_REG_ERR) ||
                  (awaddr_ff == `LRM_REG_CFG);
   assign sleep_cmd = wr_go && awaddr_ff == `LRM_REG_CTRL && wdata_ff[`LRM_CTRL_SLEEP_BIT];
   assign reset_cmd = wr_go && awaddr_ff == `LRM_REG_CTRL && wdata_ff[`LRM_CTRL_RESET_BIT];
   assign err_set_pulse = (wr_go && awaddr_ff == `LRM_REG_ERR) ? (wdata_ff[7:0] & 8'hfe) : 8'h00;
   assign st_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == `LRM_REG_STATUS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff     <= 1'b0;
         w_got_ff      <= 1'b0;
         awaddr_ff     <= 32'h0;
         wdata_ff      <= 32'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else begin
         s_axi_awready <= !aw_got_ff && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_got_ff && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
         end
         if (wr_go) begin
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || defaults) begin
         cmd_ff      <= 8'h00;
         cfg_auto_ff <= 1'b0;
      end else if (wr_go && awaddr_ff == `LRM_REG_CTRL && s_axi_wstrb[0]) begin
         cmd_ff <= wdata_ff[7:0];
      end else if (wr_go && awaddr_ff == `LRM_REG_CFG && s_axi_wstrb[0]) begin
         cfg_auto_ff <= wdata_ff[`LRM_CFG_AUTO_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr)
               `LRM_REG_CTRL:       s_axi_rdata <= {24'h0, cmd_ff};
               `LRM_REG_STATUS:     s_axi_rdata <= {16'h0, 5'h0, mode_ff, app_status_field, err_code};
               `LRM_REG_OUT_STATUS: s_axi_rdata <= {16'h0, 6'h0, lts_ff, ovc_ff};
               `LRM_REG_ERR:        s_axi_rdata <= {24'h0, err_pend_ff};
               `LRM_REG_CFG:        s_axi_rdata <= {31'h0, cfg_auto_ff};
               `LRM_REG_OPEN_LOAD:  s_axi_rdata <= {30'h0, ol_ff};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // lrm_ctrl

// [verification/lrm_ctrl_asserts.sv]
// Concurrent checks on the ports of the mode and fault controller.
// Assumes a bind into lrm_ctrl with the same init parameter.
`timescale 1ns/1ps
module lrm_ctrl_chk #(
   parameter int INIT_CYC = 20
) (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Observed ports
   input wire logic [7:0]  overcurrent_det,
   input wire logic        global_thermal_hot,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [7:0]  chan_on,
   input wire logic [7:0]  chan_hiz,
   input wire logic        lin_enable,
   input wire logic        lin_wake_detect,
   input wire logic [2:0]  mode
);
   logic [15:0] init_cnt_ff;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk) begin
      if (!aresetn || mode != 3'h1) init_cnt_ff <= 16'h0000;
      else init_cnt_ff <= init_cnt_ff + 16'h0001;
   end
   a_por_quiet: assert property (mode == 3'h0 |-> chan_hiz == 8'hff && !lin_enable)
      else $error("unpowered outputs active");
   a_init_quiet: assert property (mode == 3'h1 |-> chan_hiz == 8'hff && !lin_enable)
      else $error("init outputs active");
   a_init_bound: assert property (init_cnt_ff <= INIT_CYC + 8)
      else $error("init too long");
   a_sleep_state: assert property (mode == 3'h4 |-> chan_on == 8'h00 && lin_wake_detect && !lin_enable)
      else $error("sleep outputs wrong");
   a_lin_mode: assert property (lin_enable |-> mode == 3'h2 || mode == 3'h6)
      else $error("lin on in wrong mode");
   a_gtsd_enter: assert property ($rose(global_thermal_hot) && mode == 3'h2 |-> ##[1:6] mode == 3'h6)
      else $error("shutdown not entered");
   a_gtsd_state: assert property (mode == 3'h6 |-> chan_on == 8'h00 && lin_enable)
      else $error("shutdown outputs wrong");
   a_oc_cut: assert property ((overcurrent_det[0] && chan_on[0]) [*8] |=> !chan_on[0])
      else $error("overcurrent not latched off");
   a_wake_init: assert property (mode != 3'h4 && $past(mode) == 3'h4 |-> mode == 3'h1 || mode == 3'h0)
      else $error("sleep left not to init");
   a_normal_entry: assert property (mode == 3'h2 && $past(mode) != 3'h2 |-> $past(mode) inside {3'h1, 3'h3, 3'h6})
      else $error("normal entered wrongly");
   a_app_mask: assert property (s_axi_rvalid && s_axi_rdata[10:8] == 3'h6 |-> s_axi_rdata[6:5] == 2'b01)
      else $error("status bits wrong in shutdown");
   c_gtsd: cover property (mode == 3'h6);
   c_wake: cover property (mode == 3'h4 ##1 mode == 3'h1);
   c_oc: cover property (chan_on[0] ##1 !chan_on[0]);
endmodule // lrm_ctrl_chk
bind lrm_ctrl lrm_ctrl_chk #(.INIT_CYC(INIT_CYC)) u_chk (.aclk, .aresetn, .overcurrent_det, .global_thermal_hot,
   .s_axi_rvalid, .s_axi_rdata, .chan_on, .chan_hiz, .lin_enable, .lin_wake_detect, .mode);

// [verification/lrm_lin_master.sv]
// Behavioural LIN master: bus activity and wake pulses.
// Assumes the slave sees the bus as a dominant-high level.
`timescale 1ns/1ps
module lrm_lin_master (
   // Clock
   input  wire logic aclk,
   // Activity enable
   input  wire logic chatter,
   // Bus level
   output logic      lin_rx_dominant
);
   logic [5:0] tick_ff = 6'h00;
   logic       wake_ff = 1'b0;
   always @(posedge aclk) tick_ff <= tick_ff + 6'h01;
   // Short dominant pulses keep the idle timer of the slave from running out.
   assign lin_rx_dominant = wake_ff || (chatter && tick_ff < 6'h02);
   task automatic wake(input int n);
      @(posedge aclk) wake_ff <= 1'b1;
      repeat (n) @(posedge aclk);
      wake_ff <= 1'b0;
   endtask
endmodule // lrm_lin_master

// [verification/lrm_ctrl_bench.sv]
// Self-checking bench of the mode and fault controller.
// Assumes lrm_ctrl, its checker and the LIN master model.
`timescale 1ns/1ps
module lrm_ctrl_bench
   import lrm_pkg::*;
;
   localparam int IDLE_CYC = 200;
   localparam int INIT_CYC = 20;
   localparam int WAKE_CYC = 10;
   localparam int OC_CYC   = 4;
   logic aclk = 1'b0, aresetn = 1'b0, chatter = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic supply_por_ok = 1'b0, supply_uv_low = 1'b0, supply_uv_high = 1'b1;
   logic global_thermal_hot = 1'b0, global_thermal_cool = 1'b1, lin_rx_dominant;
   logic [7:0] overcurrent_det = 8'h00, chan_on, chan_hiz;
   logic [1:0] local_thermal_det = 2'b00, open_load_det = 2'b00;
   logic node_address_pin_ok = 1'b0, position_config_pin_ok = 1'b0, config_read_done = 1'b0;
   logic lin_enable, lin_wake_detect, config_read_req;
   logic [2:0] mode;
   int fail_count = 0, tests_run = 0;
   lrm_ctrl #(.IDLE_CYC(IDLE_CYC), .INIT_CYC(INIT_CYC), .WAKE_CYC(WAKE_CYC), .OC_CYC(OC_CYC)) DUT (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .supply_por_ok, .supply_uv_low, .supply_uv_high, .global_thermal_hot, .global_thermal_cool,
      .overcurrent_det, .local_thermal_det, .open_load_det, .lin_rx_dominant, .node_address_pin_ok,
      .position_config_pin_ok, .config_read_done, .chan_on, .chan_hiz, .lin_enable, .lin_wake_detect,
      .config_read_req, .mode);
   lrm_lin_master u_lin (.aclk, .chatter, .lin_rx_dominant);
   initial forever #20 aclk = ~aclk;
   task automatic chk(input string n, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
   endtask
   task automatic wm(input lrm_mode_e m);
      for (int i = 0; i < 400 && mode !== m; i++) @(negedge aclk);
      chk("mode", mode, m);
   endtask
   task automatic t_power;
      logic [1:0]  r;
      logic [31:0] d;
      chk("hiz", chan_hiz, 8'hff);
      chk("lin", lin_enable, 1'b0);
      @(posedge aclk) supply_por_ok <= 1'b1;
      wm(LRM_INIT);
      chk("req", config_read_req, 1'b1);
      chk("hiz", chan_hiz, 8'hff);
      @(posedge aclk) config_read_done <= 1'b1;
      wm(LRM_SLEEP);
      @(posedge aclk) node_address_pin_ok <= 1'b1;
      position_config_pin_ok <= 1'b1;
      u_lin.wake(2 * WAKE_CYC);
      wm(LRM_NORMAL);
      chk("lin", lin_enable, 1'b1);
      rd(32'h4, d);
      chk("err", d[2:0], 3'h1);
      rd(32'h4, d);
      chk("err", d[2:0], 3'h0);
      wr(32'h40, 32'h0, r);
      chk("bresp", r, 2'h2);
      $display("power test done");
   endtask
   task automatic t_fault;
      logic [1:0]  r;
      logic [31:0] d;
      wr(32'h0, 32'h89, r);
      repeat (3) @(negedge aclk);
      chk("on", chan_on, 8'h89);
      @(posedge aclk) overcurrent_det <= 8'h01;
      repeat (12) @(negedge aclk);
      rd(32'h4, d);
      chk("app", d[6], 1'b0);
      @(posedge aclk) local_thermal_det <= 2'b10;
      repeat (12) @(negedge aclk);
      chk("on", chan_on, 8'h08);
      rd(32'h4, d);
      chk("app", d[6], 1'b1);
      @(posedge aclk) overcurrent_det <= 8'h00;
      local_thermal_det <= 2'b00;
      open_load_det <= 2'b10;
      rd(32'h8, d);
      chk("out", d[9:0], 10'h201);
      wr(32'h0, 32'h08, r);
      rd(32'h8, d);
      chk("out", d[9:0], 10'h000);
      rd(32'h14, d);
      chk("open", d[1:0], 2'b10);
      wr(32'h0, 32'h88, r);
      repeat (3) @(negedge aclk);
      chk("on", chan_on, 8'h88);
      $display("fault test done");
   endtask
   task automatic t_gtsd;
      logic [31:0] d;
      @(posedge aclk) overcurrent_det <= 8'h08;
      repeat (12) @(negedge aclk);
      @(posedge aclk) global_thermal_hot <= 1'b1;
      global_thermal_cool <= 1'b0;
      wm(LRM_GTSD);
      chk("on", chan_on, 8'h00);
      chk("lin", lin_enable, 1'b1);
      rd(32'h4, d);
      chk("app", d[6:5], 2'b01);
      @(posedge aclk) global_thermal_hot <= 1'b0;
      global_thermal_cool <= 1'b1;
      overcurrent_det <= 8'h00;
      wm(LRM_NORMAL);
      rd(32'h4, d);
      chk("app", d[6:5], 2'b10);
      $display("shutdown test done");
   endtask
   task automatic t_sleep;
      logic [1:0] r;
      logic [31:0] d;
      wr(32'h0, 32'h200, r);
      rd(32'h4, d);
      chk("err", d[2:0], 3'h1);
      wr(32'h0, 32'h100, r);
      wm(LRM_SLEEP);
      chk("on", chan_on, 8'h00);
      chk("wake", lin_wake_detect, 1'b1);
      u_lin.wake(WAKE_CYC / 2);
      repeat (8) @(negedge aclk);
      chk("mode", mode, LRM_SLEEP);
      u_lin.wake(2 * WAKE_CYC);
      wm(LRM_NORMAL);
      @(posedge aclk) chatter <= 1'b0;
      wm(LRM_SLEEP);
      $display("sleep test done");
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      give_verdict();
   end
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      t_power();
      t_fault();
      t_gtsd();
      t_sleep();
      give_verdict();
   end
endmodule // lrm_ctrl_bench
